// *** rtl/mpwd_pkg.sv ***
// Package with timing constants, power states and carried event structs.
package mpwd_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned PRESS_MIN_MS = 16;
  localparam int unsigned PRESS_CYCLES = (CLK_HZ / 1000) * PRESS_MIN_MS;
  localparam int unsigned WARN_US = 100;
  localparam int unsigned WARN_CYCLES = (CLK_HZ / 1000000) * WARN_US;
  localparam int unsigned WDOG_MS = 1000;
  localparam int unsigned WDOG_CYCLES = (CLK_HZ / 1000) * WDOG_MS;
  localparam int unsigned NUM_BTN = 4;
  localparam int unsigned BTN_PWR = 0;
  localparam int unsigned BTN_RST = 1;
  localparam int unsigned BTN_SLP = 2;
  localparam int unsigned BTN_LID = 3;

  typedef enum logic [2:0] {
    MPWD_OFF = 3'h0,
    MPWD_WAIT_RAILS = 3'h1,
    MPWD_RUN = 3'h2,
    MPWD_WARN = 3'h3,
    MPWD_SLEEP = 3'h4
  } mpwd_state_t;

  typedef struct packed {
    logic power;
    logic reset;
    logic sleep;
    logic lid_close;
    logic lid_open;
  } mpwd_press_t;

  typedef struct packed {
    logic battery_low;
    logic wake;
    logic bus_alert;
  } mpwd_level_t;
endpackage

// *** rtl/mpwd_seq.sv ***
// Power sequencer with button qualification and watchdog for the module pins.
`timescale 1ns/100ps
// Contract
// - Power-good high means carrier rails usable; carrier drives it only then.
// - Power button acts on its qualified falling edge, active low.
// - Reset button low for 16 ms resets the module.
// - Battery-low low level means battery event.
// - Wake low level requests wake from a low power state.
// - Suspend-warning goes low ahead of entering a low power state.
// - S3 power output low in S3, S4 or S5.
// - Soft-off output low whenever in S4 or S5.
// - Sleep button falling edge toggles sleep; held low at least 16 ms.
// - Lid switch enters or leaves sleep; each level held 16 ms.
// - Watchdog restarts on falling edge of the kick input.
// - Watchdog expiry rises when no kick arrives in time.
// - Expiry stays until software clear, reset or power down.
// - Alert low level is a pending management bus event.
module mpwd_seq #(
  parameter int unsigned PRESS_CNT = mpwd_pkg::PRESS_CYCLES,
  parameter int unsigned WARN_CNT = mpwd_pkg::WARN_CYCLES,
  parameter int unsigned WDOG_CNT = mpwd_pkg::WDOG_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic carrier_rails_good,
  input wire logic power_button_n,
  input wire logic reset_button_n,
  input wire logic sleep_button_n,
  input wire logic lid_switch_n,
  input wire logic battery_low_n,
  input wire logic wake_n,
  input wire logic watchdog_kick_n,
  input wire logic mgmt_bus_alert_n,
  input wire logic wdog_clear,
  input wire logic sleep_request,
  output logic suspend_warning_n,
  output logic sleep_s3_power_n,
  output logic soft_off_state_n,
  output logic watchdog_expired,
  output logic module_reset,
  output mpwd_pkg::mpwd_press_t press_events,
  output mpwd_pkg::mpwd_level_t level_events,
  output mpwd_pkg::mpwd_state_t power_state
);
  import mpwd_pkg::*;

  initial begin
    if (PRESS_CNT < 2 || WARN_CNT < 1 || WDOG_CNT < 2) begin
      $error("mpwd_seq: counts too small");
    end
  end

  logic [NUM_BTN-1:0] raw_n;
  logic [NUM_BTN-1:0] sync1;
  logic [NUM_BTN-1:0] sync2;
  logic [NUM_BTN-1:0] stable;
  logic [NUM_BTN-1:0] fall;
  logic [NUM_BTN-1:0] rise;
  logic [2:0] lvl1;
  logic [2:0] lvl2;
  logic kick1;
  logic kick2;
  logic kick3;
  logic kick_fall;
  logic [31:0] wdog_cnt;
  logic [31:0] warn_cnt;
  logic want_sleep;
  logic want_wake;
  logic wdog_fire;

  assign raw_n = {lid_switch_n, sleep_button_n, reset_button_n, power_button_n};

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1 <= '1;
      sync2 <= '1;
      lvl1 <= 3'h7;
      lvl2 <= 3'h7;
      kick1 <= 1'b1;
      kick2 <= 1'b1;
    end else begin
      sync1 <= raw_n;
      sync2 <= sync1;
      lvl1 <= {battery_low_n, wake_n, mgmt_bus_alert_n};
      lvl2 <= lvl1;
      kick1 <= watchdog_kick_n;
      kick2 <= kick1;
    end
  end

  // minimum time filter for low and high levels; a level must persist before it is accepted.
  for (genvar i = 0; i < NUM_BTN; i++) begin : g_btn
    logic [31:0] cnt;
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        cnt <= 32'h0;
        stable[i] <= 1'b1;
        fall[i] <= 1'b0;
        rise[i] <= 1'b0;
      end else begin
        fall[i] <= 1'b0;
        rise[i] <= 1'b0;
        if (sync2[i] == stable[i]) begin
          cnt <= 32'h0;
        end else if (cnt == PRESS_CNT - 1) begin
          cnt <= 32'h0;
          stable[i] <= sync2[i];
          fall[i] <= ~sync2[i];
          rise[i] <= sync2[i];
        end else begin
          cnt <= cnt + 32'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      level_events <= '0;
    end else begin
      level_events.battery_low <= ~lvl2[2];
      level_events.wake <= ~lvl2[1];
      level_events.bus_alert <= ~lvl2[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      press_events <= '0;
    end else begin
      press_events.power <= fall[BTN_PWR];
      press_events.reset <= fall[BTN_RST];
      press_events.sleep <= fall[BTN_SLP];
      press_events.lid_close <= fall[BTN_LID];
      press_events.lid_open <= rise[BTN_LID];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      module_reset <= 1'b0;
    end else begin
      module_reset <= fall[BTN_RST];
    end
  end

  assign want_sleep = fall[BTN_SLP] | fall[BTN_LID] | sleep_request;
  assign want_wake = fall[BTN_SLP] | rise[BTN_LID] | ~lvl2[1] | fall[BTN_PWR];

  // power state sequencing; rails gate every way to run.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      power_state <= MPWD_OFF;
      warn_cnt <= 32'h0;
    end else begin
      case (power_state)
        MPWD_OFF: begin
          if (fall[BTN_PWR]) begin
            power_state <= MPWD_WAIT_RAILS;
          end
        end
        MPWD_WAIT_RAILS: begin
          if (carrier_rails_good) begin
            power_state <= MPWD_RUN;
          end
        end
        MPWD_RUN: begin
          if (!carrier_rails_good) begin
            power_state <= MPWD_WAIT_RAILS;
          end else if (fall[BTN_PWR] || want_sleep) begin
            warn_cnt <= 32'h0;
            power_state <= MPWD_WARN;
          end
        end
        MPWD_WARN: begin
          if (warn_cnt == WARN_CNT - 1) begin
            power_state <= MPWD_SLEEP;
          end else begin
            warn_cnt <= warn_cnt + 32'h1;
          end
        end
        MPWD_SLEEP: begin
          if (want_wake) begin
            power_state <= MPWD_WAIT_RAILS;
          end
        end
        default: begin
          power_state <= MPWD_OFF;
        end
      endcase
    end
  end

  // state outputs; soft off covers the off state.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      suspend_warning_n <= 1'b1;
      sleep_s3_power_n <= 1'b0;
      soft_off_state_n <= 1'b0;
    end else begin
      suspend_warning_n <= !(power_state == MPWD_WARN || power_state == MPWD_SLEEP);
      sleep_s3_power_n <= !(power_state == MPWD_OFF || power_state == MPWD_SLEEP);
      soft_off_state_n <= power_state != MPWD_OFF;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      kick3 <= 1'b1;
    end else begin
      kick3 <= kick2;
    end
  end
  assign kick_fall = kick3 & ~kick2;

  // watchdog count; runs only while the system runs.
  always_ff @(posedge core_clk) begin
    if (sys_rst || power_state != MPWD_RUN || kick_fall) begin
      wdog_cnt <= 32'h0;
    end else if (wdog_cnt == WDOG_CNT - 1) begin
      wdog_cnt <= 32'h0;
    end else begin
      wdog_cnt <= wdog_cnt + 32'h1;
    end
  end
  assign wdog_fire = power_state == MPWD_RUN && !kick_fall && wdog_cnt == WDOG_CNT - 1;

  // sticky expiry; software may clear it in any state, but a fire wins the cycle.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      watchdog_expired <= 1'b0;
    end else if (wdog_fire) begin
      watchdog_expired <= 1'b1;
    end else if (wdog_clear || power_state == MPWD_OFF) begin
      watchdog_expired <= 1'b0;
    end
  end

  a_warn_before_sleep: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(power_state == MPWD_SLEEP) |-> !suspend_warning_n) else $error("no warning");
  a_soft_off_level: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(power_state) == MPWD_OFF && !$past(sys_rst) |-> !soft_off_state_n)
    else $error("soft off not low");
  a_s3_level: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(power_state) == MPWD_SLEEP && !$past(sys_rst) |-> !sleep_s3_power_n)
    else $error("s3 not low");
  a_run_needs_rails: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(power_state == MPWD_RUN) |-> $past(carrier_rails_good)) else $error("run no rails");
  a_wdog_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    watchdog_expired && !wdog_clear && power_state != MPWD_OFF |=> watchdog_expired)
    else $error("expiry dropped");
  sequence s_kick;
    kick_fall && power_state == MPWD_RUN;
  endsequence
  a_kick_restart: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_kick |=> wdog_cnt == 32'h0) else $error("kick ignored");
  a_wdog_fire: assert property (@(posedge core_clk) disable iff (sys_rst)
    power_state == MPWD_RUN && wdog_cnt == WDOG_CNT - 1 && !kick_fall |=> watchdog_expired)
    else $error("no expiry");
  a_reset_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
    fall[BTN_RST] |=> module_reset ##1 !module_reset) else $error("reset pulse");
  a_alert_level: assert property (@(posedge core_clk) disable iff (sys_rst)
    !lvl2[0] |=> level_events.bus_alert) else $error("alert missed");
  a_press_filter: assert property (@(posedge core_clk) disable iff (sys_rst)
    fall[BTN_PWR] |-> $past(!sync2[BTN_PWR])) else $error("unfiltered press");
endmodule

// *** test/mpwd_carrier.sv ***
// Carrier board model that reports rails good some cycles after power is asked for.
`timescale 1ns/100ps
module mpwd_carrier #(
  parameter int RAIL_DLY = 5
) (
  input wire logic core_clk,
  input wire logic soft_off_state_n,
  input wire logic rail_fault,
  output logic carrier_rails_good
);
  int cnt = 0;
  always @(posedge core_clk) begin
    if (!soft_off_state_n || rail_fault) begin
      cnt <= 0;
    end else if (cnt < RAIL_DLY) begin
      cnt <= cnt + 1;
    end
  end
  // A fault drops the rail at once, because the module must never see stale power-good.
  assign carrier_rails_good = (cnt == RAIL_DLY) && !rail_fault;
endmodule

// *** test/test_mpwd_seq.sv ***
// Self-checking bench for the power sequencer with a carrier model.
`timescale 1ns/100ps
module test_mpwd_seq;
  import mpwd_pkg::*;
  logic core_clk = 0, sys_rst = 1, rails, fault = 0, clr = 0, sreq = 0, kick_n = 1;
  logic [3:0] btn_n = 4'hF;
  logic [2:0] lvl_n = 3'h7;
  logic w_n, s3_n, off_n, expired, mrst, p_s3, p_w;
  mpwd_press_t pe;
  mpwd_level_t le;
  mpwd_state_t st;
  logic [5:0] exp_q[$];
  int n_fail = 0, compares = 0, cycles = 0, seed = 33598, r;

  mpwd_seq #(.PRESS_CNT(4), .WARN_CNT(3), .WDOG_CNT(16)) dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .carrier_rails_good(rails),
    .power_button_n(btn_n[BTN_PWR]), .reset_button_n(btn_n[BTN_RST]),
    .sleep_button_n(btn_n[BTN_SLP]), .lid_switch_n(btn_n[BTN_LID]),
    .battery_low_n(lvl_n[2]), .wake_n(lvl_n[1]), .mgmt_bus_alert_n(lvl_n[0]),
    .watchdog_kick_n(kick_n), .wdog_clear(clr), .sleep_request(sreq),
    .suspend_warning_n(w_n), .sleep_s3_power_n(s3_n), .soft_off_state_n(off_n),
    .watchdog_expired(expired), .module_reset(mrst), .press_events(pe),
    .level_events(le), .power_state(st));

  mpwd_carrier carrier_u (.core_clk(core_clk), .soft_off_state_n(off_n),
    .rail_fault(fault), .carrier_rails_good(rails));

  always #25 core_clk = ~core_clk;

  task automatic print_verdict();
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [5:0] got, input logic [5:0] want);
    compares++;
    if (got !== want) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic press(input int b, input int n, input logic [5:0] e);
    if (e !== 6'h00) exp_q.push_back(e);
    btn_n[b] = 1'b0;
    cyc(n);
    btn_n[b] = 1'b1;
    // The release must outlast the filter too, or a quick second press is lost.
    cyc(n);
  endtask

  task automatic wait_st(input mpwd_state_t s);
    int i;
    for (i = 0; i < 60 && st !== s; i++) cyc(1);
    chk(6'(st), 6'(s));
  endtask

  // Each event pulse is paired with the oldest note the driver left.
  // Sampled at the falling edge, where the registered outputs have settled.
  always @(negedge core_clk) begin
    if (!sys_rst && {mrst, pe} !== 6'h00) begin
      if (exp_q.size() == 0) chk({mrst, pe}, 6'h00);
      else chk({mrst, pe}, exp_q.pop_front());
    end
    if (!sys_rst && p_s3 === 1'b1 && s3_n === 1'b0) chk(6'(p_w), 6'h00);
    p_s3 <= s3_n;
    p_w <= w_n;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    cyc(12);
    sys_rst = 0;
    chk({2'h0, w_n, s3_n, off_n, expired}, 6'h08);
    press(BTN_PWR, 2, 6'h00);
    cyc(4);
    chk(6'(st), 6'(MPWD_OFF));
    press(BTN_PWR, 10, 6'h10);
    wait_st(MPWD_RUN);
    chk(6'(off_n), 6'h01);
    fault = 1;
    wait_st(MPWD_WAIT_RAILS);
    fault = 0;
    wait_st(MPWD_RUN);
    repeat (4) begin
      kick_n = 0;
      cyc(2);
      kick_n = 1;
      cyc(8);
    end
    chk(6'(expired), 6'h00);
    cyc(30);
    chk(6'(expired), 6'h01);
    kick_n = 0;
    clr = 1;
    cyc(1);
    clr = 0;
    kick_n = 1;
    cyc(2);
    chk(6'(expired), 6'h00);
    repeat (4) begin
      r = $random(seed);
      lvl_n = r[2:0];
      cyc(4);
      chk(6'(le), {3'h0, ~lvl_n});
    end
    lvl_n = 3'h7;
    press(BTN_SLP, 10, 6'h04);
    wait_st(MPWD_SLEEP);
    cyc(1);
    chk({3'h0, w_n, s3_n, off_n}, 6'h01);
    press(BTN_SLP, 10, 6'h04);
    wait_st(MPWD_RUN);
    exp_q.push_back(6'h02);
    exp_q.push_back(6'h01);
    btn_n[BTN_LID] = 0;
    wait_st(MPWD_SLEEP);
    btn_n[BTN_LID] = 1;
    wait_st(MPWD_RUN);
    sreq = 1;
    cyc(1);
    sreq = 0;
    wait_st(MPWD_SLEEP);
    lvl_n[1] = 0;
    wait_st(MPWD_RUN);
    lvl_n = 3'h7;
    press(BTN_RST, 10, 6'h28);
    press(BTN_PWR, 10, 6'h10);
    wait_st(MPWD_SLEEP);
    press(BTN_PWR, 10, 6'h10);
    wait_st(MPWD_RUN);
    chk(6'(expired), 6'h01);
    sys_rst = 1;
    cyc(2);
    sys_rst = 0;
    chk({2'h0, w_n, s3_n, off_n, expired}, 6'h08);
    chk(6'(st), 6'(MPWD_OFF));
    cyc(10);
    chk(6'(exp_q.size()), 6'h00);
    print_verdict();
  end
endmodule
